// ---- verilog/fes_sequencer.sv ----
// Flash erase command sequencer with suspend, resume and bank swap
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fes_consts.svh"

module fes_sequencer #(
    parameter logic [15:0] WIN_CYC = 16'(`FES_WIN_CYC),
    parameter logic [23:0] LIMIT_CYC = `FES_LIMIT_CYC
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire fes_pkg::fes_bus_type bus_i,
    input wire logic [7:0] array_rdata_i,
    input wire logic array_done_i,
    input wire logic [15:0] vec_addr_i,
    output logic [7:0] rdata_o,
    output logic array_start_o,
    output fes_pkg::fes_arr_type array_req_o,
    output logic array_hold_o,
    output logic [15:0] vec_addr_o
);
    import fes_pkg::*;

    // ********************************
    // Types, state and helpers
    // ********************************
    typedef enum logic [2:0] {
        ST_READ,
        ST_PROG,
        ST_CHIP,
        ST_SWAIT,
        ST_SERASE,
        ST_SUSPP,
        ST_SUSP,
        ST_FAIL
    } fes_state_type;

    localparam logic [11:0] SUSP_CYC = 12'(`FES_SUSP_CYC);

    fes_state_type state_ff;
    logic [2:0] step_ff;
    logic [7:0] sel_ff;
    logic phase_ff;
    logic started_ff;
    logic hold_ff;
    logic op_prog_ff;
    logic poll_ff;
    logic tog_ff;
    logic [15:0] win_cnt_ff;
    logic [11:0] susp_cnt_ff;
    logic [23:0] elapsed_ff;
    logic [7:0] swe_ff;
    logic swap_ff;
    logic [15:0] prog_addr_ff;
    logic [7:0] rdata_ff;
    logic start_ff;
    fes_arr_type req_ff;
    logic [15:0] vec_ff;

    // Match one command cycle against its expected address and code
    function automatic logic cyc_ok(input logic [15:0] a, input logic [7:0] d,
                                    input logic [11:0] ea, input logic [7:0] ed);
        cyc_ok = (a[11:0] == ea) && (d == ed);
    endfunction : cyc_ok

    // One-hot sector of an address
    function automatic logic [7:0] sect_bit(input logic [15:0] a);
        sect_bit = 8'h01 << a[14:12];
    endfunction : sect_bit

    // ********************************
    // Command decode
    // ********************************
    logic wr_fl;
    logic in_sel;
    logic running;
    logic ev_rst;
    logic ev_prog;
    logic ev_chip;
    logic ev_sect;
    logic ev_add;
    logic ev_stop;
    logic ev_win_end;
    logic ev_susp;
    logic ev_susp_done;
    logic ev_resume;
    logic ev_pre_done;
    logic ev_done;
    logic ev_timeout;
    logic step_ok;

    // Events are decoded once for all processes
    always_comb begin
        wr_fl = bus_i.wr && bus_i.addr[15];
        in_sel = |(sel_ff & sect_bit(bus_i.addr));
        running = state_ff inside {ST_PROG, ST_CHIP, ST_SERASE};
        case (step_ff)
            3'd0: step_ok = cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_A, `FES_CD_AA);
            3'd1: step_ok = cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_B, `FES_CD_55);
            3'd3: step_ok = cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_A, `FES_CD_AA);
            3'd4: step_ok = cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_B, `FES_CD_55);
            default: step_ok = 1'b0;
        endcase
        ev_rst = wr_fl && (bus_i.wdata == `FES_CD_RST)
            && (state_ff inside {ST_READ, ST_FAIL}) && (step_ff != 3'd6);
        ev_prog = wr_fl && (state_ff == ST_READ) && (step_ff == 3'd6);
        ev_chip = wr_fl && (state_ff == ST_READ) && (step_ff == 3'd5)
            && cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_A, `FES_CD_CHIP)
            && (&swe_ff);
        ev_sect = wr_fl && (state_ff == ST_READ) && (step_ff == 3'd5)
            && (bus_i.wdata == `FES_CD_SECT);
        ev_add = wr_fl && (state_ff == ST_SWAIT)
            && (bus_i.wdata == `FES_CD_SECT);
        ev_stop = wr_fl && (state_ff == ST_SWAIT)
            && (bus_i.wdata == `FES_CD_SUSP) && in_sel;
        ev_win_end = (state_ff == ST_SWAIT) && !ev_add && !ev_stop
            && (win_cnt_ff == WIN_CYC - 16'h0001);
        // Only the running sector erase takes a suspend
        ev_susp = wr_fl && (state_ff == ST_SERASE)
            && (bus_i.wdata == `FES_CD_SUSP) && in_sel;
        ev_pre_done = (state_ff == ST_CHIP) && !phase_ff && array_done_i;
        ev_done = array_done_i && ((state_ff inside {ST_PROG, ST_SERASE, ST_SUSPP})
            || ((state_ff == ST_CHIP) && phase_ff));
        ev_susp_done = (state_ff == ST_SUSPP) && !array_done_i
            && (susp_cnt_ff == SUSP_CYC - 12'h001);
        // Resume is heard only while suspended, never while erasing
        ev_resume = wr_fl && (state_ff == ST_SUSP)
            && (bus_i.wdata == `FES_CD_SECT) && in_sel;
        ev_timeout = running && !array_done_i && (elapsed_ff == LIMIT_CYC);
    end

    // ********************************
    // Sequencer state
    // ********************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_ff <= ST_READ;
        end else begin
            case (state_ff)
                ST_READ: begin
                    if (ev_prog) begin
                        state_ff <= ST_PROG;
                    end else if (ev_chip) begin
                        state_ff <= ST_CHIP;
                    end else if (ev_sect) begin
                        state_ff <= ST_SWAIT;
                    end
                end
                ST_PROG, ST_CHIP: begin
                    if (ev_done) begin
                        state_ff <= ST_READ;
                    end else if (ev_timeout) begin
                        state_ff <= ST_FAIL;
                    end
                end
                ST_SWAIT: begin
                    if (ev_stop) begin
                        state_ff <= ST_SUSP;
                    end else if (ev_win_end) begin
                        state_ff <= ST_SERASE;
                    end
                end
                ST_SERASE: begin
                    if (ev_done) begin
                        state_ff <= ST_READ;
                    end else if (ev_timeout) begin
                        state_ff <= ST_FAIL;
                    end else if (ev_susp) begin
                        state_ff <= ST_SUSPP;
                    end
                end
                ST_SUSPP: begin
                    if (ev_done) begin
                        state_ff <= ST_READ;
                    end else if (ev_timeout) begin
                        state_ff <= ST_FAIL;
                    end else if (ev_susp_done) begin
                        state_ff <= ST_SUSP;
                    end
                end
                ST_SUSP: begin
                    // A repeated suspend falls through untouched
                    if (ev_resume) begin
                        state_ff <= ST_SERASE;
                    end
                end
                ST_FAIL: begin
                    if (ev_rst) begin
                        state_ff <= ST_READ;
                    end
                end
                default: state_ff <= ST_READ;
            endcase
        end
    end

    // Unlock cycle counter; a stray write drops back to the first cycle
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_rst || (state_ff != ST_READ)) begin
            step_ff <= 3'd0;
        end else if (wr_fl) begin
            if (step_ff == 3'd2) begin
                if (cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_A, `FES_CD_80)) begin
                    step_ff <= 3'd3;
                end else if (cyc_ok(bus_i.addr, bus_i.wdata, `FES_ADR_A, `FES_CD_A0)) begin
                    step_ff <= 3'd6;
                end else begin
                    step_ff <= 3'd0;
                end
            end else if (step_ok) begin
                step_ff <= step_ff + 3'd1;
            end else begin
                step_ff <= 3'd0;
            end
        end
    end

    // Sectors picked for erasure
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_chip || ev_prog) begin
            sel_ff <= 8'h00;
        end else if (ev_sect) begin
            sel_ff <= sect_bit(bus_i.addr);
        end else if (ev_add) begin
            sel_ff <= sel_ff | sect_bit(bus_i.addr);
        end
    end

    // Window timer restarts on every accepted erase code
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_sect || ev_add || (state_ff != ST_SWAIT)) begin
            win_cnt_ff <= 16'h0000;
        end else begin
            win_cnt_ff <= win_cnt_ff + 16'h0001;
        end
    end

    // Suspend latency; the array is held from the suspend write on
    always_ff @(posedge clock_i) begin
        if (srst_i || (state_ff != ST_SUSPP)) begin
            susp_cnt_ff <= 12'h000;
        end else begin
            susp_cnt_ff <= susp_cnt_ff + 12'h001;
        end
    end

    // Elapsed time of the running algorithm; frozen while suspended
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_prog || ev_chip || ev_pre_done || ev_win_end || ev_resume) begin
            elapsed_ff <= 24'h00_0000;
        end else if (running && (elapsed_ff != LIMIT_CYC)) begin
            elapsed_ff <= elapsed_ff + 24'h00_0001;
        end
    end

    // Chip erase phase: cell preprogramming first, then the erase
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_chip) begin
            phase_ff <= 1'b0;
        end else if (ev_pre_done) begin
            phase_ff <= 1'b1;
        end
    end

    // Whether the array erase was ever launched for this sector set
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_sect) begin
            started_ff <= 1'b0;
        end else if (ev_win_end || (ev_resume && !started_ff)) begin
            started_ff <= 1'b1;
        end
    end

    // Array hold while suspending or suspended out of a running erase; a window stop leaves it low
    always_ff @(posedge clock_i) begin
        if (srst_i || ev_resume || ev_done || ev_timeout) begin
            hold_ff <= 1'b0;
        end else if (ev_susp) begin
            hold_ff <= 1'b1;
        end
    end

    // ********************************
    // Array requests
    // ********************************
    // A stopped window never reached the array, so resume launches it fresh
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            start_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            start_ff <= ev_prog || ev_chip || ev_pre_done || ev_win_end
                || (ev_resume && !started_ff);
            if (ev_prog) begin
                req_ff <= '{FES_OP_PROG, bus_i.addr, bus_i.wdata, 8'h00};
            end else if (ev_chip) begin
                req_ff <= '{FES_OP_PREPROG, 16'h0000, 8'h00, 8'hFF};
            end else if (ev_pre_done) begin
                req_ff <= '{FES_OP_ERASE_ALL, 16'h0000, 8'hFF, 8'hFF};
            end else if (ev_win_end || (ev_resume && !started_ff)) begin
                req_ff <= '{FES_OP_ERASE_SECT, 16'h0000, 8'hFF, sel_ff};
            end
        end
    end

    // Kind of operation and expected polling value
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            op_prog_ff <= 1'b0;
            poll_ff <= 1'b0;
            prog_addr_ff <= 16'h0000;
        end else if (ev_prog) begin
            op_prog_ff <= 1'b1;
            poll_ff <= ~bus_i.wdata[7];
            prog_addr_ff <= bus_i.addr;
        end else if (ev_chip || ev_sect) begin
            op_prog_ff <= 1'b0;
            poll_ff <= 1'b0;
        end
    end

    // ********************************
    // Software registers
    // ********************************
    // Bank swap is plain storage; the host keeps it steady while busy
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            swe_ff <= `FES_SWE_RST;
            swap_ff <= 1'b0;
        end else if (bus_i.wr) begin
            if (bus_i.addr == `FES_SWE_ADDR) begin
                swe_ff <= bus_i.wdata;
            end
            if (bus_i.addr == `FES_FSR_ADDR) begin
                swap_ff <= bus_i.wdata[`FES_FSR_SWAP];
            end
        end
    end

    // ********************************
    // Read path
    // ********************************
    logic [1:0] busy_bank;
    logic show_status;
    logic [7:0] status;

    // Reads aimed at a busy bank see status; the other bank reads data
    always_comb begin
        case (state_ff)
            ST_PROG: busy_bank = 2'b01 << prog_addr_ff[14];
            ST_CHIP, ST_FAIL: busy_bank = 2'b11;
            ST_SWAIT, ST_SERASE, ST_SUSPP: busy_bank = {|sel_ff[7:4], |sel_ff[3:0]};
            default: busy_bank = 2'b00;
        endcase
        if (state_ff == ST_SUSP) begin
            show_status = in_sel;
        end else begin
            show_status = busy_bank[bus_i.addr[14]];
        end
        status = 8'h00;
        status[`FES_ST_POLL] = (state_ff == ST_SUSP) ? 1'b0 : poll_ff;
        status[`FES_ST_TOG] = tog_ff;
        status[`FES_ST_TO] = (state_ff == ST_FAIL);
        status[`FES_ST_WIN] = !op_prog_ff && (state_ff != ST_SWAIT);
    end

    // Toggle flips per status read and freezes once timed out
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tog_ff <= 1'b0;
        end else if (bus_i.rd && bus_i.addr[15] && show_status && !ev_timeout
                     && (state_ff != ST_FAIL)) begin
            tog_ff <= ~tog_ff;
        end
    end

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clock_i) begin
        if (srst_i || !bus_i.rd) begin
            rdata_ff <= 8'h00;
        end else if (bus_i.addr == `FES_SWE_ADDR) begin
            rdata_ff <= swe_ff;
        end else if (bus_i.addr == `FES_FSR_ADDR) begin
            rdata_ff <= {5'h00, state_ff == ST_FAIL, swap_ff, state_ff == ST_READ};
        end else if (bus_i.addr[15]) begin
            rdata_ff <= show_status ? status : array_rdata_i;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ********************************
    // Vector redirect
    // ********************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            vec_ff <= 16'h0000;
        end else if (swap_ff && (vec_addr_i[14:12] == `FES_UP_VEC)) begin
            vec_ff <= {vec_addr_i[15], `FES_LOW_VEC, vec_addr_i[11:0]};
        end else begin
            vec_ff <= vec_addr_i;
        end
    end

    assign rdata_o = rdata_ff;
    assign array_start_o = start_ff;
    assign array_req_o = req_ff;
    assign array_hold_o = hold_ff;
    assign vec_addr_o = vec_ff;
endmodule : fes_sequencer
`default_nettype wire

// ---- verilog/fes_consts.svh ----
// Constants for the flash erase command sequencer
//
// Contract
// - Chip erase is six back-to-back writes; erasure starts after the sixth. The code starts preprogramming after the sixth and the erase once that is done.
// - Chip erase programs every cell to zero first, then erases.
// - Chip erase is ignored unless every sector write-enable bit is one.
// - Sector erase is six writes; sixth writes 30h in sector, opens window.
// - Inside the window each 30h write adds its sector to the set.
// - Erasure starts when the window lapses; later codes are rejected.
// - Erase-window flag reads zero while the window is open, one after.
// - Toggle flag stops toggling in the cycle the timeout flag rises.
// - Polling flag and timeout flag change together; the code keeps the polling flag at its value when the timeout flag rises.
// - Timeout flag reads zero within the time limit, one past it.
// - Erase suspend is one write of B0h inside a selected sector.
// - Suspend acts only during sector erase or its window.
// - A second suspend while suspended is ignored.
// - Suspend in the window ends it and stops the erase at once.
// - Suspend during erasure reaches the suspended state within 20 us.
// - While suspended, other sectors read their stored array data.
// - Resume is 30h inside a selected sector and continues the erase.
// - Resume while erasure is running is ignored.
// - A busy bank is not read; the other bank reads normally.
// - With bank swap on, upper vector fetches go to the lower sector.
// - A finished algorithm returns the device to read/reset.
`ifndef FES_CONSTS_SVH
`define FES_CONSTS_SVH
// Register offsets and reset values
`define FES_SWE_ADDR 16'h0FE0
`define FES_FSR_ADDR 16'h0FE1
`define FES_SWE_RST 8'h00
`define FES_FSR_RDY 0
`define FES_FSR_SWAP 1
`define FES_FSR_TO 2
// Command cycle addresses and codes
`define FES_ADR_A 12'h0AAA
`define FES_ADR_B 12'h0555
`define FES_CD_AA 8'hAA
`define FES_CD_55 8'h55
`define FES_CD_80 8'h80
`define FES_CD_A0 8'hA0
`define FES_CD_CHIP 8'h10
`define FES_CD_SECT 8'h30
`define FES_CD_SUSP 8'hB0
`define FES_CD_RST 8'hF0
// Status word bit positions
`define FES_ST_POLL 7
`define FES_ST_TOG 6
`define FES_ST_TO 5
`define FES_ST_WIN 3
// Vector sectors
`define FES_LOW_VEC 3'h3
`define FES_UP_VEC 3'h7
// Timing
`define FES_CLK_NS 8
`define FES_WIN_NS 50000
`define FES_SUSP_NS 20000
`define FES_WIN_CYC ((`FES_WIN_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_SUSP_CYC (`FES_SUSP_NS / `FES_CLK_NS)
`define FES_LIMIT_CYC 24'h0F_4240
`endif

// ---- verilog/fes_pkg.sv ----
// Types shared by the flash erase command sequencer
package fes_pkg;
    // Array operation codes
    typedef enum logic [1:0] {
        FES_OP_PROG,
        FES_OP_PREPROG,
        FES_OP_ERASE_ALL,
        FES_OP_ERASE_SECT
    } fes_op_type;

    // CPU side bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fes_bus_type;

    // Request to the flash array macro
    typedef struct packed {
        fes_op_type op;
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] sect;
    } fes_arr_type;
endpackage : fes_pkg

// ---- test/fes_array_model.sv ----
// Behavioural flash array behind the sequencer
`timescale 1ns/1ns
`default_nettype none
module fes_array_model #(
    parameter int LAT = 40
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [15:0] addr_i,
    input wire logic start_i,
    input wire logic hold_i,
    input wire logic stall_i,
    output logic [7:0] rdata_o,
    output logic done_o
);
    int left_ff;
    // Stored byte is a pattern of the address
    assign rdata_o = addr_i[7:0] ^ {addr_i[14:12], 5'h00};
    // Counts down unless held; a stall mimics a locked cell
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            left_ff <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                left_ff <= LAT;
            end else if (left_ff > 0 && !hold_i && !stall_i) begin
                left_ff <= left_ff - 1;
                done_o <= (left_ff == 1);
            end
        end
    end
endmodule : fes_array_model
`default_nettype wire

// ---- test/fes_sequencer_props.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module fes_sequencer_props
    import fes_pkg::*;
#(
    parameter logic [15:0] WIN_CYC = 16'h0014,
    parameter logic [23:0] LIMIT_CYC = 24'h00_00C8
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire fes_pkg::fes_bus_type bus_i,
    input wire logic array_done_i,
    input wire logic [15:0] vec_addr_i,
    input wire logic [7:0] rdata_o,
    input wire logic array_start_o,
    input wire fes_pkg::fes_arr_type array_req_o,
    input wire logic array_hold_o,
    input wire logic [15:0] vec_addr_o
);
    logic rst_d_ff;
    logic [15:0] quiet_ff;
    // Reset echo masks $past across reset
    always_ff @(posedge clock_i) begin
        rst_d_ff <= srst_i;
    end
    // Cycles since the last 30h write, saturating
    always_ff @(posedge clock_i) begin
        if (srst_i || (bus_i.wr && bus_i.wdata == 8'h30)) begin
            quiet_ff <= 16'h0000;
        end else if (quiet_ff != 16'hFFFF) begin
            quiet_ff <= quiet_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i || rst_d_ff);
    sequence s_prep_done;
        array_req_o.op == FES_OP_PREPROG && array_done_i;
    endsequence
    sequence s_erase_all_start;
        array_start_o && array_req_o.op == FES_OP_ERASE_ALL;
    endsequence
    AST_CHIP_FIRST: assert property (array_start_o && array_req_o.op == FES_OP_PREPROG |->
        $past(bus_i.wr && bus_i.wdata == 8'h10)) else $error("preprogram without chip code");
    AST_CHIP_SECOND: assert property (s_prep_done |=> s_erase_all_start)
        else $error("no erase after preprogram");
    AST_SECT_QUIET: assert property (array_start_o && array_req_o.op == FES_OP_ERASE_SECT |->
        quiet_ff >= WIN_CYC - 16'h0001 || $past(bus_i.wr)) else $error("sector erase inside window");
    AST_SECT_MASK: assert property (array_start_o && array_req_o.op == FES_OP_ERASE_SECT |->
        array_req_o.sect != 8'h00) else $error("empty sector set");
    AST_HOLD_RISE: assert property ($rose(array_hold_o) |-> $past(bus_i.wr && bus_i.wdata == 8'hB0))
        else $error("hold without suspend");
    AST_HOLD_FALL: assert property ($fell(array_hold_o) |-> $past(bus_i.wr && bus_i.wdata == 8'h30))
        else $error("hold fell without resume");
    AST_HOLD_NO_START: assert property (array_hold_o |-> !array_start_o)
        else $error("start while held");
    AST_START_ONE: assert property (array_start_o |=> !array_start_o)
        else $error("start too long");
    AST_RDATA_ZERO: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("stray read data");
    AST_VEC_PASS: assert property ($past(vec_addr_i[14:12]) != 3'h7 |-> vec_addr_o == $past(vec_addr_i))
        else $error("vector altered");
endmodule : fes_sequencer_props
`default_nettype wire

// ---- test/fes_sequencer_tb.sv ----
// Self-checking bench for the flash erase sequencer
`timescale 1ns/1ns
`default_nettype none
module fes_sequencer_tb;
    import fes_pkg::*;
    localparam logic [15:0] WIN = 16'h0014;
    localparam logic [23:0] LIM = 24'h00_00C8;
    logic clock_i = 1'b0, srst_i = 1'b1;
    fes_bus_type bus_i = '0;
    logic [15:0] vec_addr_i = 16'hFFCC;
    logic stall = 1'b0;
    logic [7:0] array_rdata_i, rdata_o, got, st;
    logic array_done_i, array_start_o, array_hold_o;
    logic [15:0] vec_addr_o;
    fes_arr_type array_req_o;
    int n_errors = 0, cmp_count = 0;
    // Clock at 125 MHz
    always #4 clock_i = ~clock_i;
    fes_sequencer #(.WIN_CYC(WIN), .LIMIT_CYC(LIM)) i_fes_sequencer (.clock_i(clock_i), .srst_i(srst_i),
        .bus_i(bus_i), .array_rdata_i(array_rdata_i), .array_done_i(array_done_i), .vec_addr_i(vec_addr_i),
        .rdata_o(rdata_o), .array_start_o(array_start_o), .array_req_o(array_req_o),
        .array_hold_o(array_hold_o), .vec_addr_o(vec_addr_o));
    fes_array_model i_fes_array_model (.clock_i(clock_i), .srst_i(srst_i), .addr_i(bus_i.addr),
        .start_i(array_start_o), .hold_i(array_hold_o), .stall_i(stall), .rdata_o(array_rdata_i),
        .done_o(array_done_i));
    function automatic logic [7:0] exp_arr(input logic [15:0] a);
        return a[7:0] ^ {a[14:12], 5'h00};
    endfunction : exp_arr
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // A request stands until the next call replaces it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{a, d, 1'b1, 1'b0};
    endtask : wr
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock_i);
            bus_i <= '0;
        end
    endtask : idle
    task automatic rd(input logic [15:0] a);
        @(posedge clock_i);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        bus_i <= '0;
        #1;
        got = rdata_o;
    endtask : rd
    task automatic seq(input logic [15:0] a, input logic [7:0] d);
        wr(16'h8AAA, 8'hAA);
        wr(16'h8555, 8'h55);
        wr(16'h8AAA, 8'h80);
        wr(16'h8AAA, 8'hAA);
        wr(16'h8555, 8'h55);
        wr(a, d);
    endtask : seq
    // Bounded wait for a start (sel 0) or done (sel 1) pulse
    task automatic wait_for(input int n, input logic want, input logic sel);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            @(posedge clock_i);
            seen = sel ? (array_done_i === 1'b1) : (array_start_o === 1'b1);
        end
        chk("pulse", want, seen);
        if (want && !seen) begin
            conclude();
        end
    endtask : wait_for
    task automatic t_regs();
        rd(16'h0FE0);
        chk("swe reset", 8'h00, got);
        wr(16'h0FE0, 8'hA5);
        rd(16'h0FE0);
        chk("swe rw", 8'hA5, got);
        wr(16'h0FE1, 8'h02);
        vec_addr_i <= 16'hCFCC;
        rd(16'h0FE1);
        chk("swap bit", 8'h02, got & 8'h02);
        chk("vector other", 16'hCFCC, vec_addr_o);
        rd(16'h0100);
        chk("unmapped", 8'h00, got);
        wr(16'h0FE1, 8'h00);
        vec_addr_i <= 16'hFFCC;
        idle(2);
        chk("vector swapped", 16'hBFCC, vec_addr_o);
        idle(1);
        chk("vector plain", 16'hFFCC, vec_addr_o);
    endtask : t_regs
    task automatic t_chip();
        wr(16'h0FE0, 8'h7F);
        seq(16'h8AAA, 8'h10);
        idle(1);
        wait_for(10, 1'b0, 1'b0);
        wr(16'h0FE0, 8'hFF);
        seq(16'h8AAA, 8'h10);
        idle(1);
        wait_for(4, 1'b1, 1'b0);
        chk("chip op", FES_OP_PREPROG, array_req_o.op);
        wr(16'h9000, 8'hB0);
        idle(2);
        chk("hold in chip", 1'b0, array_hold_o);
        wait_for(60, 1'b1, 1'b0);
        chk("chip op2", FES_OP_ERASE_ALL, array_req_o.op);
        wait_for(60, 1'b1, 1'b1);
        rd(16'h9010);
        chk("after chip", exp_arr(16'h9010), got);
    endtask : t_chip
    task automatic t_sect();
        seq(16'h9000, 8'h30);
        wr(16'hA000, 8'h30);
        rd(16'h9000);
        chk("window open", 8'h00, got & 8'h08);
        wait_for(40, 1'b1, 1'b0);
        chk("sect op", FES_OP_ERASE_SECT, array_req_o.op);
        chk("sect mask", 8'h06, array_req_o.sect);
        rd(16'hB000);
        st = got;
        chk("busy flags", 8'h08, st & 8'hA8);
        rd(16'hB000);
        chk("toggle", st[6] ^ 1'b1, got[6]);
        rd(16'hC000);
        chk("other bank", exp_arr(16'hC000), got);
        wr(16'hA000, 8'h30);
        idle(1);
        wait_for(4, 1'b0, 1'b0);
        wr(16'h9000, 8'hB0); // shortened gap
        idle(2);
        chk("hold", 1'b1, array_hold_o);
        idle(2500);
        wr(16'h9000, 8'hB0);
        rd(16'hB000);
        chk("suspended read", exp_arr(16'hB000), got);
        chk("hold kept", 1'b1, array_hold_o);
        wr(16'hA000, 8'h30);
        idle(2);
        chk("resumed", 1'b0, array_hold_o);
        wait_for(80, 1'b1, 1'b1);
        rd(16'h9000);
        chk("after sect", exp_arr(16'h9000), got);
    endtask : t_sect
    task automatic t_stop();
        seq(16'h9000, 8'h30);
        wr(16'h9000, 8'hB0);
        idle(1);
        wait_for(40, 1'b0, 1'b0);
        wr(16'h9000, 8'h30);
        idle(1);
        wait_for(60, 1'b1, 1'b0);
        wait_for(80, 1'b1, 1'b1);
    endtask : t_stop
    task automatic t_tout();
        stall <= 1'b1;
        seq(16'h9000, 8'h30);
        idle(1);
        wait_for(40, 1'b1, 1'b0);
        idle(210);
        rd(16'h9000);
        st = got;
        chk("timeout flags", 8'h28, st & 8'hA8);
        rd(16'h9000);
        chk("toggle frozen", st[6], got[6]);
        @(posedge clock_i);
        srst_i <= 1'b1;
        stall <= 1'b0;
        @(posedge clock_i);
        srst_i <= 1'b0;
        rd(16'h9000);
        chk("after reset", exp_arr(16'h9000), got);
    endtask : t_tout
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        srst_i <= 1'b0;
        t_regs();
        t_chip();
        t_sect();
        t_stop();
        t_tout();
        conclude();
    end
endmodule : fes_sequencer_tb
bind fes_sequencer fes_sequencer_props #(.WIN_CYC(WIN_CYC), .LIMIT_CYC(LIMIT_CYC)) i_fes_sequencer_props (
    .clock_i(clock_i), .srst_i(srst_i), .bus_i(bus_i), .array_done_i(array_done_i),
    .vec_addr_i(vec_addr_i), .rdata_o(rdata_o), .array_start_o(array_start_o),
    .array_req_o(array_req_o), .array_hold_o(array_hold_o), .vec_addr_o(vec_addr_o));
`default_nettype wire
